/* logic/ddc_pkg.sv */
// Shared constants, coefficient sets and carrier types of the downconverter
package ddc_pkg;

  localparam int SAMPLE_W = 14;
  localparam int DATA_W   = 16;
  localparam int ADDR_W   = 10;
  localparam int REG_W    = 8;
  localparam int FREQ_W   = 32;
  localparam int PHASE_W  = 16;
  localparam int PATHS    = 4;

  localparam logic [ADDR_W-1:0] ADDR_SYNC_CTRL   = 10'h100;
  localparam logic [ADDR_W-1:0] ADDR_FIR_CTRL    = 10'h102;
  localparam logic [ADDR_W-1:0] ADDR_HB_CTRL     = 10'h103;
  localparam logic [ADDR_W-1:0] ADDR_TUNER_CTRL  = 10'h11D;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_B0     = 10'h11E;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_B1     = 10'h11F;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_B2     = 10'h120;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_B3     = 10'h121;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_LO    = 10'h122;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_HI    = 10'h123;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  localparam int TUNER_EN_BIT      = 0;
  localparam int DITHER_EN_BIT     = 1;
  localparam int SYNC_NCO_EN_BIT   = 3;
  localparam int SYNC_NCO_ONCE_BIT = 4;
  localparam int SYNC_HB_EN_BIT    = 5;
  localparam int SYNC_HB_ONCE_BIT  = 6;
  localparam int FIR_EN_BIT        = 0;
  localparam int HB_HIGHPASS_BIT   = 1;
  localparam int HB_REVERSE_BIT    = 2;
  localparam int HB_PHASE_BIT      = 3;

  // Sine generator: Q14 amplitude, quarter turn offset for cosine
  localparam int MIX_SHIFT = 14;
  localparam logic [PHASE_W-1:0] QUARTER_TURN = 16'h4000;
  localparam logic [PHASE_W-1:0] HALF_TURN    = 16'h8000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  localparam int ACC_W      = 44;
  localparam int HB_TAPS    = 19;
  localparam int HB_CENTER  = 9;
  localparam int HB_PAIRS   = 5;
  localparam int HB_SHIFT   = 20;
  localparam logic signed [20:0] HB_MID = 21'sd524287;
  localparam logic signed [20:0] HB_COEF [HB_PAIRS] =
    '{21'sd844, -21'sd6189, 21'sd25080, -21'sd79170, 21'sd321584};

  localparam int FIR_TAPS  = 66;
  localparam int FIR_PAIRS = 33;
  localparam int FIR_SHIFT = 21;
  localparam logic signed [21:0] FIR_COEF [FIR_PAIRS] = '{
    22'sd383, 22'sd1431, 22'sd1950, 22'sd96, -22'sd2661, -22'sd1750,
    22'sd2476, 22'sd2388, -22'sd3867, -22'sd5150, 22'sd3788, 22'sd7513,
    -22'sd4511, -22'sd11914, 22'sd3650, 22'sd16484, -22'sd2818,
    -22'sd23200, -22'sd48, 22'sd30748, 22'sd3976, -22'sd41019,
    -22'sd11147, 22'sd53608, 22'sd21818, -22'sd71611, -22'sd40300,
    22'sd98830, 22'sd74264, -22'sd152696, -22'sd161248, 22'sd337056,
    22'sd922060};

  typedef struct packed {
    logic high_pass;
    logic dec_phase;
    logic fir_en;
  } filt_ctrl_t;

  typedef struct packed {
    logic                     real_mode;
    logic signed [DATA_W-1:0] a_i;
    logic signed [DATA_W-1:0] a_q;
    logic signed [DATA_W-1:0] b_i;
    logic signed [DATA_W-1:0] b_q;
  } out_word_t;

endpackage

/* logic/path_filter.sv */
// One real path: decimating half-band followed by optional 66-tap filter
`timescale 1ns/10ps
module path_filter (
  input  wire logic                      core_clk, // Sample clock
  input  wire logic                      rst,      // Async reset
  input  wire logic                      in_en,    // Take one sample
  input  wire logic                      restart,  // Restart decimation
  input  wire ddc_pkg::filt_ctrl_t       ctrl,     // Filter controls
  input  wire logic signed [15:0]        x,        // Input sample
  output logic signed [15:0]             y,        // Output sample
  output logic                           y_valid   // Output pulse
);
  logic signed [15:0] hb_line [ddc_pkg::HB_TAPS];
  logic signed [15:0] hb_nxt  [ddc_pkg::HB_TAPS];
  logic signed [15:0] fir_line [ddc_pkg::FIR_TAPS];
  logic signed [15:0] fir_nxt  [ddc_pkg::FIR_TAPS];
  logic signed [ddc_pkg::ACC_W-1:0] hb_acc;
  logic signed [ddc_pkg::ACC_W-1:0] fir_acc;
  logic signed [15:0] hb_val;
  logic signed [15:0] fir_val;
  logic               ph_r;
  wire                fire = in_en && (ph_r == ctrl.dec_phase);

  // Odd taps other than the centre are zero, so only even pairs are summed
  always_comb begin
    hb_nxt[0] = x;
    for (int i = 1; i < ddc_pkg::HB_TAPS; i++) hb_nxt[i] = hb_line[i-1];
    hb_acc = 44'(ddc_pkg::HB_MID) * 44'(hb_nxt[ddc_pkg::HB_CENTER]);
    if (ctrl.high_pass) hb_acc = -hb_acc;
    for (int k = 0; k < ddc_pkg::HB_PAIRS; k++) begin
      hb_acc = hb_acc + 44'(ddc_pkg::HB_COEF[k]) *
        (44'(hb_nxt[2*k]) + 44'(hb_nxt[ddc_pkg::HB_TAPS-1-2*k]));
    end
    hb_val = hb_acc[ddc_pkg::HB_SHIFT +: 16];
  end

  always_comb begin
    fir_nxt[0] = hb_val;
    for (int i = 1; i < ddc_pkg::FIR_TAPS; i++) fir_nxt[i] = fir_line[i-1];
    fir_acc = '0;
    for (int k = 0; k < ddc_pkg::FIR_PAIRS; k++) begin
      fir_acc = fir_acc + 44'(ddc_pkg::FIR_COEF[k]) *
        (44'(fir_nxt[k]) + 44'(fir_nxt[ddc_pkg::FIR_TAPS-1-k]));
    end
    fir_val = fir_acc[ddc_pkg::FIR_SHIFT +: 16];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_r    <= 1'b0;
      y       <= '0;
      y_valid <= 1'b0;
      for (int i = 0; i < ddc_pkg::HB_TAPS; i++) hb_line[i] <= '0;
      for (int i = 0; i < ddc_pkg::FIR_TAPS; i++) fir_line[i] <= '0;
    end else begin
      y_valid <= fire;
      if (restart) ph_r <= 1'b0;
      else if (in_en) ph_r <= ~ph_r;
      if (in_en) hb_line <= hb_nxt;
      if (fire) begin
        fir_line <= fir_nxt;
        y        <= ctrl.fir_en ? fir_val : hb_val;
      end
    end
  end
endmodule

/* logic/dual_channel_downconverter.sv */
// Downconversion chain: registers, tuning oscillator, mixers, filters, output
`timescale 1ns/10ps
module dual_channel_downconverter (
  input  wire logic                        core_clk,         // Sample clock
  input  wire logic                        rst,              // Async reset
  input  wire logic signed [13:0]          sample_a,         // Channel A
  input  wire logic signed [13:0]          sample_b,         // Channel B
  input  wire logic                        sample_valid,     // Samples here
  output logic                             sample_ready,     // Can take
  input  wire logic                        sync_pin,         // Align strobe
  input  wire logic                        quarter_shift_en, // Rate/8 shift
  input  wire logic [9:0]                  reg_addr,         // Reg address
  input  wire logic [7:0]                  reg_wdata,        // Write data
  input  wire logic                        reg_wr,           // Write strobe
  input  wire logic                        reg_rd,           // Read strobe
  output logic [7:0]                       reg_rdata,        // Read data
  output ddc_pkg::out_word_t               out_word,         // Result word
  output logic                             out_valid,        // Word ready
  input  wire logic                        out_ready         // Sink takes
);

  // Register file
  logic [7:0]  sync_control_r;
  logic [7:0]  fir_control_r;
  logic [7:0]  halfband_control_r;
  logic [7:0]  tuner_control_r;
  logic [31:0] tuning_frequency_word_r;
  logic [15:0] tuning_phase_offset_r;
  logic [7:0]  rd_mux;

  wire wr_sync  = reg_wr && (reg_addr == ddc_pkg::ADDR_SYNC_CTRL);
  wire wr_fir   = reg_wr && (reg_addr == ddc_pkg::ADDR_FIR_CTRL);
  wire wr_hb    = reg_wr && (reg_addr == ddc_pkg::ADDR_HB_CTRL);
  wire wr_tuner = reg_wr && (reg_addr == ddc_pkg::ADDR_TUNER_CTRL);
  wire wr_f0    = reg_wr && (reg_addr == ddc_pkg::ADDR_FREQ_B0);
  wire wr_f1    = reg_wr && (reg_addr == ddc_pkg::ADDR_FREQ_B1);
  wire wr_f2    = reg_wr && (reg_addr == ddc_pkg::ADDR_FREQ_B2);
  wire wr_f3    = reg_wr && (reg_addr == ddc_pkg::ADDR_FREQ_B3);
  wire wr_plo   = reg_wr && (reg_addr == ddc_pkg::ADDR_PHASE_LO);
  wire wr_phi   = reg_wr && (reg_addr == ddc_pkg::ADDR_PHASE_HI);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_control_r          <= ddc_pkg::REG_RESET;
      fir_control_r           <= ddc_pkg::REG_RESET;
      halfband_control_r      <= ddc_pkg::REG_RESET;
      tuner_control_r         <= ddc_pkg::REG_RESET;
      tuning_frequency_word_r <= '0;
      tuning_phase_offset_r   <= '0;
    end else begin
      if (wr_sync) sync_control_r <= reg_wdata;
      if (wr_fir) fir_control_r <= reg_wdata;
      if (wr_hb) halfband_control_r <= reg_wdata;
      if (wr_tuner) tuner_control_r <= reg_wdata;
      if (wr_f0) tuning_frequency_word_r[7:0] <= reg_wdata;
      if (wr_f1) tuning_frequency_word_r[15:8] <= reg_wdata;
      if (wr_f2) tuning_frequency_word_r[23:16] <= reg_wdata;
      if (wr_f3) tuning_frequency_word_r[31:24] <= reg_wdata;
      if (wr_plo) tuning_phase_offset_r[7:0] <= reg_wdata;
      if (wr_phi) tuning_phase_offset_r[15:8] <= reg_wdata;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    if (reg_addr == ddc_pkg::ADDR_SYNC_CTRL) rd_mux = sync_control_r;
    else if (reg_addr == ddc_pkg::ADDR_FIR_CTRL) rd_mux = fir_control_r;
    else if (reg_addr == ddc_pkg::ADDR_HB_CTRL) rd_mux = halfband_control_r;
    else if (reg_addr == ddc_pkg::ADDR_TUNER_CTRL) rd_mux = tuner_control_r;
    else if (reg_addr == ddc_pkg::ADDR_FREQ_B0)
      rd_mux = tuning_frequency_word_r[7:0];
    else if (reg_addr == ddc_pkg::ADDR_FREQ_B1)
      rd_mux = tuning_frequency_word_r[15:8];
    else if (reg_addr == ddc_pkg::ADDR_FREQ_B2)
      rd_mux = tuning_frequency_word_r[23:16];
    else if (reg_addr == ddc_pkg::ADDR_FREQ_B3)
      rd_mux = tuning_frequency_word_r[31:24];
    else if (reg_addr == ddc_pkg::ADDR_PHASE_LO)
      rd_mux = tuning_phase_offset_r[7:0];
    else if (reg_addr == ddc_pkg::ADDR_PHASE_HI)
      rd_mux = tuning_phase_offset_r[15:8];
    else rd_mux = ddc_pkg::REG_RESET;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) reg_rdata <= ddc_pkg::REG_RESET;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // Control decode
  wire tuner_en  = tuner_control_r[ddc_pkg::TUNER_EN_BIT];
  wire dither_en = tuner_control_r[ddc_pkg::DITHER_EN_BIT];
  wire reverse   = halfband_control_r[ddc_pkg::HB_REVERSE_BIT];
  ddc_pkg::filt_ctrl_t fctrl;
  assign fctrl.high_pass = halfband_control_r[ddc_pkg::HB_HIGHPASS_BIT];
  assign fctrl.dec_phase = halfband_control_r[ddc_pkg::HB_PHASE_BIT];
  assign fctrl.fir_en    = fir_control_r[ddc_pkg::FIR_EN_BIT];

  // Alignment strobe: the pin is asynchronous, so two flops come first
  logic sync_meta_r;
  logic sync_sync_r;
  logic sync_last_r;
  logic qshift_meta_r;
  logic qshift_r;
  logic nco_armed_r;
  logic hb_armed_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_meta_r   <= 1'b0;
      sync_sync_r   <= 1'b0;
      sync_last_r   <= 1'b0;
      qshift_meta_r <= 1'b0;
      qshift_r      <= 1'b0;
    end else begin
      sync_meta_r   <= sync_pin;
      sync_sync_r   <= sync_meta_r;
      sync_last_r   <= sync_sync_r;
      // Shift enable is a free-running pin level as well
      qshift_meta_r <= quarter_shift_en;
      qshift_r      <= qshift_meta_r;
    end
  end

  wire sync_edge = sync_sync_r & ~sync_last_r;
  wire nco_sync  = sync_edge & sync_control_r[ddc_pkg::SYNC_NCO_EN_BIT] &
                   (~sync_control_r[ddc_pkg::SYNC_NCO_ONCE_BIT] |
                    nco_armed_r);
  wire hb_sync   = sync_edge & sync_control_r[ddc_pkg::SYNC_HB_EN_BIT] &
                   (~sync_control_r[ddc_pkg::SYNC_HB_ONCE_BIT] | hb_armed_r);

  // A write re-arms the one-shot mode; a write beats a same-cycle strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nco_armed_r <= 1'b0;
      hb_armed_r  <= 1'b0;
    end else begin
      nco_armed_r <= wr_sync | (nco_armed_r & ~nco_sync);
      hb_armed_r  <= wr_sync | (hb_armed_r & ~hb_sync);
    end
  end

  // Sample flow: the whole chain holds while the output buffer is full
  logic buf_in_ready;
  wire  adv = sample_valid & buf_in_ready;
  assign sample_ready = buf_in_ready;

  // Tuning oscillator, shared by both channels
  logic [31:0] phase_acc_r;
  logic [15:0] lfsr_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_acc_r <= '0;
      lfsr_r      <= ddc_pkg::LFSR_SEED;
    end else begin
      // Signed and unsigned words wrap identically modulo 2^32
      if (nco_sync) phase_acc_r <= '0;
      else if (adv)
        phase_acc_r <= phase_acc_r + tuning_frequency_word_r;
      if (adv)
        lfsr_r <= {lfsr_r[14:0],
                   lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // Offset of one step is 360/65536 degrees, added after restart
  wire [15:0] phase = phase_acc_r[31:16] +
                      tuning_phase_offset_r;
  wire [1:0]  dith_s = dither_en ? lfsr_r[1:0] : 2'h0;
  wire [1:0]  dith_c = dither_en ? lfsr_r[3:2] : 2'h0;

  // Parabolic sine: cheap and table-free, at the cost of a few percent
  // harmonic error; dither breaks up the truncation pattern.
  function automatic logic signed [15:0] wave(input logic [15:0] p,
                                             input logic [1:0]  d);
    logic [15:0] h;
    logic [31:0] prod;
    logic [16:0] mag;
    h    = {1'b0, p[14:0]};
    prod = 32'(h) * 32'(ddc_pkg::HALF_TURN - h);
    mag  = prod[28:12] + 17'(d);
    wave = p[15] ? -16'(mag[16:2]) : 16'(mag[16:2]);
  endfunction

  wire signed [15:0] sin_v = wave(phase, dith_s);
  wire signed [15:0] cos_v = wave(phase + ddc_pkg::QUARTER_TURN, dith_c);

  // Mixers, one per channel, both fed by the one oscillator
  wire signed [29:0] prod_ai = 30'(sample_a) * 30'(cos_v);
  wire signed [29:0] prod_aq = 30'(sample_a) * 30'(sin_v);
  wire signed [29:0] prod_bi = 30'(sample_b) * 30'(cos_v);
  wire signed [29:0] prod_bq = 30'(sample_b) * 30'(sin_v);

  logic signed [15:0] mix_nxt [ddc_pkg::PATHS];
  logic signed [15:0] mix_r   [ddc_pkg::PATHS];

  // Bypassed tuner passes the real stream with Q held at zero
  assign mix_nxt[0] = tuner_en ? prod_ai[ddc_pkg::MIX_SHIFT +: 16]
                               : 16'(sample_a);
  assign mix_nxt[1] = tuner_en ? -prod_aq[ddc_pkg::MIX_SHIFT +: 16]
                               : 16'h0000;
  assign mix_nxt[2] = tuner_en ? prod_bi[ddc_pkg::MIX_SHIFT +: 16]
                               : 16'(sample_b);
  assign mix_nxt[3] = tuner_en ? -prod_bq[ddc_pkg::MIX_SHIFT +: 16]
                               : 16'h0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ddc_pkg::PATHS; i++) mix_r[i] <= '0;
    end else if (adv) begin
      mix_r <= mix_nxt;
    end
  end

  // Filter paths; all share one advance and restart, so they stay aligned
  logic signed [15:0] filt_y [ddc_pkg::PATHS];
  logic [ddc_pkg::PATHS-1:0] filt_v;

  for (genvar g = 0; g < ddc_pkg::PATHS; g++) begin : g_path
    path_filter u_path (
      .core_clk (core_clk),
      .rst      (rst),
      .in_en    (adv),
      .restart  (hb_sync),
      .ctrl     (fctrl),
      .x        (mix_r[g]),
      .y        (filt_y[g]),
      .y_valid  (filt_v[g])
    );
  end

  // Output sample index drives reversal and the quarter-rate rotation
  logic [1:0] out_idx_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) out_idx_r <= 2'h0;
    else if (hb_sync) out_idx_r <= 2'h0;
    else if (filt_v[0]) out_idx_r <= out_idx_r + 2'h1;
  end

  wire flip = reverse & out_idx_r[0];
  logic signed [15:0] rv [ddc_pkg::PATHS];
  for (genvar g = 0; g < ddc_pkg::PATHS; g++) begin : g_rev
    assign rv[g] = flip ? -filt_y[g] : filt_y[g];
  end

  // Rate/8 at the input is a quarter of the decimated rate: each output
  // advances by 90 degrees, so the rotation needs no multiplier.
  function automatic logic signed [15:0] rot(input logic signed [15:0] i,
                                            input logic signed [15:0] q,
                                            input logic [1:0] k);
    case (k)
      2'h0: rot = i;
      2'h1: rot = -q;
      2'h2: rot = -i;
      default: rot = q;
    endcase
  endfunction

  wire real_mode = ~tuner_en | qshift_r;
  ddc_pkg::out_word_t word_nxt;

  assign word_nxt.real_mode = real_mode;
  assign word_nxt.a_i = qshift_r ? rot(rv[0], rv[1], out_idx_r)
                                 : rv[0];
  assign word_nxt.b_i = qshift_r ? rot(rv[2], rv[3], out_idx_r)
                                 : rv[2];
  assign word_nxt.a_q = real_mode ? 16'h0000 : rv[1];
  assign word_nxt.b_q = real_mode ? 16'h0000 : rv[3];

  // Holding stage in front of the buffer
  ddc_pkg::out_word_t hold_r;
  logic               fresh_r;
  wire                push = fresh_r & buf_in_ready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_r  <= '0;
      fresh_r <= 1'b0;
    end else begin
      if (filt_v[0]) hold_r <= word_nxt;
      fresh_r <= filt_v[0] | (fresh_r & ~push);
    end
  end

  // Two-entry output buffer; a stalled sink backs up into the chain
  ddc_pkg::out_word_t buf0_r;
  ddc_pkg::out_word_t buf1_r;
  logic [1:0]         buf_cnt_r;
  wire                pop = out_valid & out_ready;

  assign buf_in_ready = (buf_cnt_r != 2'h2);
  assign out_valid    = (buf_cnt_r != 2'h0);
  assign out_word     = buf0_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf0_r    <= '0;
      buf1_r    <= '0;
      buf_cnt_r <= 2'h0;
    end else begin
      if (push && !pop) begin
        if (buf_cnt_r == 2'h0) buf0_r <= hold_r;
        else buf1_r <= hold_r;
        buf_cnt_r <= buf_cnt_r + 2'h1;
      end else if (pop && !push) begin
        buf0_r    <= buf1_r;
        buf_cnt_r <= buf_cnt_r - 2'h1;
      end else if (pop && push) begin
        if (buf_cnt_r == 2'h1) buf0_r <= hold_r;
        else begin
          buf0_r <= buf1_r;
          buf1_r <= hold_r;
        end
      end
    end
  end

endmodule

/* sim/adc_source.sv */
// Converter stage model feeding real samples to the chain
`timescale 1ns/10ps
module adc_source (
  input  wire logic               core_clk,     // Clock
  input  wire logic               sample_ready, // Chain can take
  input  wire logic               slow,         // Offer every other cycle
  input  wire logic signed [13:0] lvl_a,        // Level for A
  input  wire logic signed [13:0] lvl_b,        // Level for B
  output logic signed [13:0]      sample_a,     // Sample A
  output logic signed [13:0]      sample_b,     // Sample B
  output logic                    sample_valid  // Samples offered
);
  logic taken;

  initial sample_valid = 1'b0;
  always @(posedge core_clk) taken <= sample_valid && sample_ready;
  // Idle gaps carry inverted data so a stale sample cannot pass as valid
  always @(negedge core_clk) begin
    if (!sample_valid || taken) begin
      sample_valid <= slow ? !sample_valid : 1'b1;
      sample_a     <= (slow && sample_valid) ? ~lvl_a : lvl_a;
      sample_b     <= (slow && sample_valid) ? ~lvl_b : lvl_b;
    end
  end
endmodule

/* sim/ddc_sva.sv */
// Port-level assertions for the downconverter
`timescale 1ns/10ps
module ddc_sva (
  input wire logic               core_clk,     // Clock
  input wire logic               rst,          // Reset
  input wire logic               sample_valid, // Offer
  input wire logic               sample_ready, // Take
  input wire logic [9:0]         reg_addr,     // Address
  input wire logic [7:0]         reg_wdata,    // Write data
  input wire logic               reg_wr,       // Write
  input wire logic               reg_rd,       // Read
  input wire logic [7:0]         reg_rdata,    // Read data
  input wire ddc_pkg::out_word_t out_word,     // Result
  input wire logic               out_valid,    // Result valid
  input wire logic               out_ready     // Sink takes
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic mapped = (reg_addr >= 10'h11D && reg_addr <= 10'h123) ||
    reg_addr == 10'h100 || reg_addr == 10'h102 || reg_addr == 10'h103;

  pop_frees_a: assert property (
    out_valid && out_ready |=> sample_ready)
    else $error("pop did not free a buffer slot");
  full_stays_a: assert property (
    !sample_ready && !out_ready |=> !sample_ready)
    else $error("full buffer freed without a pop");
  hold_word_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("stalled word changed");
  rise_take_a: assert property (
    $rose(out_valid) |-> $past(sample_valid && sample_ready, 3))
    else $error("output without a taken sample");
  real_quad_a: assert property (
    out_valid && out_word.real_mode |->
    out_word.a_q == 16'h0000 && out_word.b_q == 16'h0000)
    else $error("real output with quadrature data");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (
    reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  wr_rd_a: assert property (
    reg_wr && mapped ##1 reg_rd && !reg_wr && $stable(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("register readback differs");
endmodule

bind dual_channel_downconverter ddc_sva u_sva (.core_clk, .rst,
  .sample_valid, .sample_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .out_word, .out_valid, .out_ready);

/* sim/tb_top.sv */
// Self-checking bench for the downconversion chain
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s expected %0d seen %0d", n, e, g); end end
module tb_top;
  logic               core_clk, rst, sample_valid, sample_ready, sync_pin;
  logic               quarter_shift_en, slow, reg_wr, reg_rd;
  logic               out_valid, out_ready;
  logic [9:0]         reg_addr;
  logic [7:0]         reg_wdata, reg_rdata, v;
  logic signed [13:0] sample_a, sample_b, lvl_a, lvl_b;
  logic signed [15:0] o0, o1;
  ddc_pkg::out_word_t out_word, w;
  int                 fail_count, compares, takes, outs, t0, n0, slip;
  logic [9:0]         regs [10] = '{10'h100, 10'h102, 10'h103, 10'h11D,
    10'h11E, 10'h11F, 10'h120, 10'h121, 10'h122, 10'h123};

  dual_channel_downconverter DUT (.core_clk, .rst, .sample_a, .sample_b,
    .sample_valid, .sample_ready, .sync_pin, .quarter_shift_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .out_word, .out_valid,
    .out_ready);
  adc_source src (.core_clk, .sample_ready, .slow, .lvl_a, .lvl_b,
    .sample_a, .sample_b, .sample_valid);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (sample_valid && sample_ready) takes++;
    if (out_valid && out_ready) outs++;
  end

  // All tasks are entered and left at a falling edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic get(output ddc_pkg::out_word_t x);
    int n;
    n = 0;
    while (out_valid !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 60) `CHK("out_valid", 1'b1, out_valid)
    x = out_word;
    @(negedge core_clk);
  endtask

  // Long enough for the 66-tap line to fill after a mode change
  task automatic settle;
    repeat (150) get(w);
  endtask

  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #400000;
    `CHK("watchdog", 0, 1)
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    sync_pin = 1'b0;
    quarter_shift_en = 1'b0;
    slow = 1'b0;
    out_ready = 1'b1;
    lvl_a = 14'sd1000;
    lvl_b = 14'sd200;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    `CHK("rdata_rst", 8'h00, reg_rdata)
    `CHK("ready_rst", 1'b1, sample_ready)
    foreach (regs[i]) begin
      wr(regs[i], 8'(8'h5A + i));
      rd(regs[i], v);
      `CHK("reg_rw", 8'h5A + i, v)
    end
    wr(10'h101, 8'hFF);
    rd(10'h101, v);
    `CHK("unmapped", 8'h00, v)
    foreach (regs[i]) wr(regs[i], 8'h00);
    settle();
    `CHK("real_mode", 1'b1, w.real_mode)
    `CHK("lp_a", 1000, w.a_i)
    `CHK("lp_b", 200, w.b_i)
    `CHK("bypass_q", 0, w.a_q)
    slow = 1'b1;
    t0 = takes;
    n0 = outs;
    repeat (40) get(w);
    slip = takes - t0 - 2 * (outs - n0);
    `CHK("decim", 1'b1, slip inside {[-3:3]})
    slow = 1'b0;
    out_ready = 1'b0;
    repeat (40) @(negedge core_clk);
    `CHK("stall_ready", 1'b0, sample_ready)
    `CHK("stall_valid", 1'b1, out_valid)
    out_ready = 1'b1;
    wr(10'h103, 8'h02);
    settle();
    `CHK("highpass", 0, w.a_i)
    wr(10'h103, 8'h04);
    settle();
    o0 = w.a_i;
    get(w);
    `CHK("rev_sum", 0, o0 + w.a_i)
    `CHK("rev_mag", 1000000, o0 * o0)
    wr(10'h103, 8'h00);
    wr(10'h102, 8'h01);
    settle();
    `CHK("fir", 1000, w.a_i)
    wr(10'h102, 8'h00);
    // The accumulator ran during the register test; a strobe zeroes it
    wr(10'h100, 8'h08);
    sync_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    sync_pin = 1'b0;
    wr(10'h11D, 8'h01);
    settle();
    `CHK("cplx", 1'b0, w.real_mode)
    `CHK("tune_i", 1'b1, w.a_i > 990 && w.a_i < 1010)
    `CHK("tune_q", 1'b1, w.a_q > -10 && w.a_q < 10)
    wr(10'h123, 8'h40);
    settle();
    `CHK("ph_i", 1'b1, w.a_i > -10 && w.a_i < 10)
    `CHK("ph_q", 1'b1, w.a_q > -1010 && w.a_q < -990)
    `CHK("ph_bq", 1'b1, w.b_q > -210 && w.b_q < -190)
    wr(10'h123, 8'h00);
    wr(10'h11D, 8'h00);
    quarter_shift_en = 1'b1;
    settle();
    o0 = w.a_i;
    get(w);
    o1 = w.a_i;
    get(w);
    `CHK("q8_real", 1'b1, w.real_mode)
    `CHK("q8_sum", 0, o0 + w.a_i)
    `CHK("q8_mag", 1000000, o0 * o0 + o1 * o1)
    wrap_up();
  end
endmodule
